// file: logic/spi_chan_pkg.sv
// shared constants and carriers for the spi master channel
`default_nettype none
package spi_chan_pkg;
    localparam int          WORD_W        = 16;
    localparam logic [3:0]  FLEN_MIN      = 4'h3;
    localparam logic [3:0]  FLEN_MAX      = 4'hf;
    localparam logic [3:0]  FLEN_DEF      = 4'h8;
    localparam logic        CPOL_DEF      = 1'b0;
    localparam logic        CPHA_DEF      = 1'b0;
    localparam logic        LSB_FIRST_DEF = 1'b0;
    localparam int          CLK_HZ        = 20_000_000;
    localparam int          SCK_MIN_HZ    = 40;
    localparam int          SCK_MAX_HZ    = 4_000_000;
    // half-period counts: fastest rounds up, slowest rounds down
    localparam int HALF_MIN = (CLK_HZ + 2*SCK_MAX_HZ - 1) / (2*SCK_MAX_HZ);
    localparam int HALF_MAX = CLK_HZ / (2*SCK_MIN_HZ);
    localparam int DIV_W    = 18;
    localparam logic [DIV_W-1:0] HALF_DEF = DIV_W'(HALF_MAX);
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_READ,
        OP_WRITE_READ
    } op_e;

    typedef struct packed {
        logic             cpol;
        logic             cpha;
        logic             lsb_first;
        logic [3:0]       flen;
        logic [DIV_W-1:0] half;
    } cfg_s;
endpackage : spi_chan_pkg
`default_nettype wire

// file: logic/spi_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`default_nettype none
module spi_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_flush,
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ff;
    logic [AW-1:0]    rd_ff;
    logic [AW:0]      cnt_ff;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_ff != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data  = mem_ff[rd_ff];
    assign push = i_in_valid && o_in_ready;
    assign pop  = o_out_valid && i_out_ready;

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_ff[wr_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_flush) begin
            wr_ff  <= '0;
            rd_ff  <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : spi_fifo
`default_nettype wire

// file: logic/spi_master_channel.sv
// spi master channel: configuration, frame engine and receive buffer
// How it works
// (RULE_01) polarity 0 idles the clock low with rising leading edges, 1 idles high with falling leading edges.
// (RULE_02) phase 0 sets data up before the leading edge and samples there; phase 1 changes on leading and samples on trailing.
// (RULE_03) bit order selects msb-first (default) or lsb-first shifting of each frame.
// (RULE_04) frame length field takes 3..15 for 4..16 bit frames and defaults to 8.
// (RULE_05) a read clocks in exactly the requested frame count and reports done only after the last one.
// (RULE_06) a write sends every supplied frame and reports done only after the last bit of the last one.
// (RULE_07) write-read sends and receives together, one received frame per sent frame.
// (RULE_08) each received frame comes back as one 16-bit word, right aligned.
// (RULE_09) the controller gives the frame count with the start of a read.
// (RULE_10) the serial clock half period is programmable for 40 Hz to 4 MHz; the shortest half period of 3 clocks gives about 3.33 MHz.
// (RULE_11) close disables the channel and restores every setting to default.
// (RULE_12) clock edges occur only while frames move; otherwise the clock rests at idle level.
`default_nettype none
module spi_master_channel
    import spi_chan_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic              i_clk_sys,
    input  wire logic              i_rst,
    input  wire logic              i_close,
    input  wire logic              i_cfg_we,
    input  wire cfg_s              i_cfg,
    input  wire logic              i_start,
    input  wire op_e               i_op,
    input  wire logic [31:0]       i_frame_count,
    input  wire logic [WORD_W-1:0] i_tx_data,
    input  wire logic              i_tx_valid,
    output logic                   o_tx_ready,
    output logic [WORD_W-1:0]      o_rx_data,
    output logic                   o_rx_valid,
    input  wire logic              i_rx_ready,
    output logic                   o_busy,
    output logic                   o_done,
    output logic                   o_cfg_err,
    output logic                   o_sck,
    output logic                   o_mosi,
    input  wire logic              i_miso
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_LEAD,
        ST_TRAIL,
        ST_PUSH
    } st_e;

    st_e              st_ff;
    cfg_s             cfg_ff;
    op_e              op_ff;
    logic [31:0]      left_ff;
    logic [DIV_W-1:0] div_ff;
    logic             tick;

    // link shifters and pin flops
    logic [WORD_W-1:0] txsh_ff;
    logic [WORD_W-1:0] rxsh_ff;
    logic [3:0]       bit_ff;
    logic             sck_ff;
    logic             mosi_ff;
    logic             busy_ff;
    logic             done_ff;
    logic             err_ff;
    logic             tx_ready_ff;

    // miso synchroniser and receive buffer path
    logic [2:0]       miso_sy_ff;
    logic             miso_q_ff;
    logic             sample_bit;
    logic [WORD_W-1:0] rx_word;
    logic             rx_push_ff;
    logic             rx_in_ready;
    logic [WORD_W-1:0] fifo_q;
    logic             fifo_v;

    // decoded operation and configuration check
    logic             uses_tx;
    logic             uses_rx;
    logic             cfg_ok;
    logic             out_bit;

    // top bit of the receive shifter and the count of the last frame
    localparam logic [3:0]  TOP_BIT    = 4'(WORD_W - 1);
    localparam logic [31:0] LAST_FRAME = 32'h0000_0001;

    assign uses_tx = (op_ff != OP_READ);
    assign uses_rx = (op_ff != OP_WRITE);
    assign cfg_ok  = (i_cfg.flen >= FLEN_MIN)
                     && (i_cfg.half >= DIV_W'(HALF_MIN))
                     && (i_cfg.half <= DIV_W'(HALF_MAX));

    // miso passes three flops; a level counts once stages two and three agree
    // limitation: the slave must hold miso four clocks past its launch edge
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            miso_sy_ff <= '0;
            miso_q_ff  <= 1'b0;
        end else begin
            miso_sy_ff <= {miso_sy_ff[1:0], i_miso};
            if (miso_sy_ff[1] == miso_sy_ff[2]) begin
                miso_q_ff <= miso_sy_ff[2];
            end
        end
    end
    assign sample_bit = miso_q_ff;

    // configuration; rejected values leave the old ones in place
    // writes while busy are ignored so a frame never changes shape mid-way
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_close) begin
            cfg_ff <= '{cpol: CPOL_DEF, cpha: CPHA_DEF,
                        lsb_first: LSB_FIRST_DEF, flen: FLEN_DEF,
                        half: HALF_DEF}; // RULE_11 RULE_04
            err_ff <= 1'b0;
        end else if (i_cfg_we && st_ff == ST_IDLE) begin
            err_ff <= !cfg_ok;
            if (cfg_ok) begin
                cfg_ff <= i_cfg; // RULE_10
            end
        end
    end

    // half-period divider, runs only during a transfer
    // restarting at each edge keeps both sck levels exactly half clocks long within a frame
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || st_ff == ST_IDLE || st_ff == ST_LOAD
            || st_ff == ST_PUSH || tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign tick = (st_ff == ST_LEAD || st_ff == ST_TRAIL)
                  && (div_ff == cfg_ff.half - 1'b1); // RULE_10

    // bit presented on mosi for the current shift position
    assign out_bit = cfg_ff.lsb_first ? txsh_ff[0] : txsh_ff[cfg_ff.flen]; // RULE_03

    // receive word right aligned; lsb-first fills from the top then shifts down
    always_comb begin
        rx_word = rxsh_ff;
        if (cfg_ff.lsb_first) begin
            rx_word = rxsh_ff >> (TOP_BIT - cfg_ff.flen); // RULE_08
        end
    end

    // frame engine
    // close lands here too, so a frame cut short simply stops mid-way
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_close) begin
            st_ff       <= ST_IDLE;
            op_ff       <= OP_WRITE;
            left_ff     <= '0;
            txsh_ff     <= '0;
            rxsh_ff     <= '0;
            bit_ff      <= '0;
            sck_ff      <= CPOL_DEF;
            mosi_ff     <= 1'b0;
            busy_ff     <= 1'b0;
            done_ff     <= 1'b0;
            tx_ready_ff <= 1'b0;
            rx_push_ff  <= 1'b0;
        end else begin
            done_ff     <= 1'b0;
            tx_ready_ff <= 1'b0;
            rx_push_ff  <= 1'b0;
            unique case (st_ff)
                ST_IDLE: begin
                    // a zero count finishes at once; the caller never waits
                    sck_ff <= cfg_ff.cpol; // RULE_12 RULE_01
                    if (i_start && i_frame_count != '0) begin
                        op_ff   <= i_op;
                        left_ff <= i_frame_count; // RULE_09 RULE_05
                        busy_ff <= 1'b1;
                        st_ff   <= ST_LOAD;
                    end else if (i_start) begin
                        done_ff <= 1'b1;
                    end
                end
                ST_LOAD: begin
                    // wait for a word to send; reads shift out zeros
                    if (!uses_tx || i_tx_valid) begin
                        txsh_ff     <= uses_tx ? i_tx_data : '0;
                        tx_ready_ff <= uses_tx; // RULE_06
                        rxsh_ff     <= '0;
                        bit_ff      <= cfg_ff.flen;
                        if (!cfg_ff.cpha) begin
                            mosi_ff <= cfg_ff.lsb_first ? i_tx_data[0]
                                       : i_tx_data[cfg_ff.flen]; // RULE_02
                            if (!uses_tx) begin
                                mosi_ff <= 1'b0;
                            end
                        end
                        st_ff <= ST_LEAD;
                    end
                end
                ST_LEAD: begin
                    // leading edge: launch for phase 1, sample for phase 0
                    if (tick) begin
                        sck_ff <= !cfg_ff.cpol; // RULE_01
                        if (cfg_ff.cpha) begin
                            mosi_ff <= out_bit; // RULE_02
                        end else begin
                            rxsh_ff <= cfg_ff.lsb_first
                                ? {sample_bit, rxsh_ff[WORD_W-1:1]}
                                : {rxsh_ff[WORD_W-2:0], sample_bit}; // RULE_07
                        end
                        st_ff <= ST_TRAIL;
                    end
                end
                ST_TRAIL: begin
                    // trailing edge: sample for phase 1, launch for phase 0
                    if (tick) begin
                        sck_ff  <= cfg_ff.cpol;
                        txsh_ff <= cfg_ff.lsb_first ? txsh_ff >> 1
                                   : txsh_ff << 1; // RULE_03
                        if (cfg_ff.cpha) begin
                            rxsh_ff <= cfg_ff.lsb_first
                                ? {sample_bit, rxsh_ff[WORD_W-1:1]}
                                : {rxsh_ff[WORD_W-2:0], sample_bit}; // RULE_02
                        end else begin
                            mosi_ff <= cfg_ff.lsb_first ? txsh_ff[1]
                                       : txsh_ff[cfg_ff.flen - 1'b1];
                        end
                        if (bit_ff == '0) begin
                            st_ff <= ST_PUSH;
                        end else begin
                            bit_ff <= bit_ff - 1'b1;
                            st_ff  <= ST_LEAD;
                        end
                    end
                end
                ST_PUSH: begin
                    // a full receive buffer holds the engine with sck idle
                    // the count only drops once the word has a place to go
                    if (!uses_rx || rx_in_ready) begin
                        rx_push_ff <= uses_rx; // RULE_05 RULE_07
                        left_ff    <= left_ff - 1'b1;
                        if (left_ff == LAST_FRAME) begin
                            busy_ff <= 1'b0;
                            done_ff <= 1'b1; // RULE_05 RULE_06
                            st_ff   <= ST_IDLE;
                        end else begin
                            st_ff <= ST_LOAD;
                        end
                    end
                end
                default: begin
                    st_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // hold the pushed word stable for the buffer input
    logic [WORD_W-1:0] rx_hold_ff;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            rx_hold_ff <= '0;
        end else if (st_ff == ST_PUSH) begin
            rx_hold_ff <= rx_word; // RULE_08
        end
    end

    // receive side only; the send side is paced by the tx handshake
    spi_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (DEPTH)
    ) u_rx_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_flush     (i_close),
        .i_in_data   (rx_hold_ff),
        .i_in_valid  (rx_push_ff),
        .o_in_ready  (rx_in_ready),
        .o_out_data  (fifo_q),
        .o_out_valid (fifo_v),
        .i_out_ready (i_rx_ready && !o_rx_valid)
    );

    // registered output stage so the top outputs come from flops
    // valid pulses at most every other cycle: rate traded for a flop output
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_close) begin
            o_rx_valid <= 1'b0;
            o_rx_data  <= '0;
        end else if (fifo_v && !o_rx_valid && i_rx_ready) begin
            o_rx_valid <= 1'b1;
            o_rx_data  <= fifo_q;
        end else begin
            o_rx_valid <= 1'b0;
        end
    end

    // status and link pins straight from their flops
    assign o_tx_ready = tx_ready_ff;
    assign o_busy     = busy_ff;
    assign o_done     = done_ff;
    assign o_cfg_err  = err_ff;
    assign o_sck      = sck_ff;
    assign o_mosi     = mosi_ff;
endmodule : spi_master_channel
`default_nettype wire

// file: tb/spi_master_channel_properties.sv
// port-level assertions for the spi master channel
`default_nettype none
module spi_master_channel_properties
    import spi_chan_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_rst,
    input wire logic        i_close,
    input wire logic        i_cfg_we,
    input wire cfg_s        i_cfg,
    input wire logic        i_start,
    input wire logic [31:0] i_frame_count,
    input wire logic        o_busy,
    input wire logic        o_done,
    input wire logic        o_cfg_err,
    input wire logic        o_sck
);
    logic       cpol_ff;
    logic [2:0] calm_ff;
    logic       cfg_ok;
    logic       take;
    assign cfg_ok = i_cfg.flen >= FLEN_MIN && i_cfg.half >= DIV_W'(HALF_MIN)
                    && i_cfg.half <= DIV_W'(HALF_MAX);
    assign take = i_cfg_we && !o_busy && !i_close;
    // mirror of the accepted polarity, so the idle level can be judged
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_close) cpol_ff <= CPOL_DEF;
        else if (take && cfg_ok) cpol_ff <= i_cfg.cpol;
    end
    // a few settle cycles after any config change before judging quiet
    always_ff @(posedge i_clk_sys) begin
        if (i_rst || i_close || i_cfg_we || o_busy) calm_ff <= 3'h0;
        else if (calm_ff != 3'h4) calm_ff <= calm_ff + 3'h1;
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    property p_idle;
        $fell(o_busy) && !$past(i_close) |-> o_sck == cpol_ff;
    endproperty
    a_idle: assert property (p_idle) else $error("sck off idle");
    property p_quiet;
        calm_ff == 3'h4 |-> $stable(o_sck);
    endproperty
    a_quiet: assert property (p_quiet) else $error("sck moved");
    property p_rate;
        o_busy && $changed(o_sck) |=> $stable(o_sck) [*2];
    endproperty
    a_rate: assert property (p_rate) else $error("sck too fast");
    property p_done;
        o_done |-> !o_busy ##1 !o_done;
    endproperty
    a_done: assert property (p_done) else $error("done bad");
    property p_start;
        i_start && !o_busy && !i_close && i_frame_count != 0 |=> o_busy;
    endproperty
    a_start: assert property (p_start) else $error("no busy");
    property p_zero;
        i_start && !o_busy && !i_close && i_frame_count == 0
            |=> o_done && !o_busy;
    endproperty
    a_zero: assert property (p_zero) else $error("zero count");
    property p_cfg_bad;
        take && !cfg_ok |=> o_cfg_err;
    endproperty
    a_cfg_bad: assert property (p_cfg_bad) else $error("cfg kept");
    property p_close;
        i_close |-> ##[1:4] (!o_busy && !o_cfg_err);
    endproperty
    a_close: assert property (p_close) else $error("close bad");
endmodule : spi_master_channel_properties
`default_nettype wire

// file: tb/spi_slave_model.sv
// behavioural spi slave answering the master channel
`default_nettype none
module spi_slave_model
    import spi_chan_pkg::*;
(
    input wire logic              i_sck,
    input wire logic              i_mosi,
    input wire cfg_s              i_cfg,
    input wire logic              i_clear,
    input wire logic [WORD_W-1:0] i_reply,
    output logic                  o_miso,
    output logic [WORD_W-1:0]     o_word,
    output int                    o_frames
);
    timeunit 1ns;
    timeprecision 1ns;
    int                n = 0;
    logic [WORD_W-1:0] sh;
    function automatic logic pick(input int k);
        return i_cfg.lsb_first ? i_reply[k] : i_reply[int'(i_cfg.flen) - k];
    endfunction : pick
    // no select line, so the bench clears the model between transfers;
    // the falling edge is used so that the new reply has settled by then
    always @(negedge i_clear) begin
        n = 0;
        sh = '0;
        o_frames = 0;
        o_miso = pick(0);
    end
    // sampling edge is leading for phase 0, trailing for phase 1
    always @(i_sck) begin
        if ((i_sck != i_cfg.cpol) != i_cfg.cpha) begin
            if (i_cfg.lsb_first) sh[n] = i_mosi;
            else sh = {sh[WORD_W-2:0], i_mosi};
            n++;
            if (n > int'(i_cfg.flen)) begin
                o_word = sh;
                o_frames++;
                n = 0;
                sh = '0;
            end
        end else begin
            o_miso = pick(n);
        end
    end
endmodule : spi_slave_model
`default_nettype wire

// file: tb/spi_master_channel_test.sv
// self-checking bench for the spi master channel
`default_nettype none
module spi_master_channel_test
    import spi_chan_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, close = 0, cfg_we = 0, start = 0, clear = 0;
    logic tx_valid = 0, rx_ready = 1, tx_ready, rx_valid, busy, done;
    logic cfg_err, sck, mosi, miso;
    cfg_s cfg = '0;
    op_e op = OP_WRITE;
    logic [31:0] count = '0;
    logic [15:0] tx_data = '0, reply = '0, rx_data, s_word;
    int s_frames, fail_count = 0, compares = 0;
    initial forever #25 clk = ~clk;
    spi_master_channel dut (.i_clk_sys(clk), .i_rst(rst), .i_close(close),
        .i_cfg_we(cfg_we), .i_cfg(cfg), .i_start(start), .i_op(op),
        .i_frame_count(count), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
        .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
        .i_rx_ready(rx_ready), .o_busy(busy), .o_done(done),
        .o_cfg_err(cfg_err), .o_sck(sck), .o_mosi(mosi), .i_miso(miso));
    spi_slave_model slave (.i_sck(sck), .i_mosi(mosi), .i_cfg(cfg),
        .i_clear(clear), .i_reply(reply), .o_miso(miso), .o_word(s_word),
        .o_frames(s_frames));
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic close_out;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic setup(input logic pol, pha, lsb, input logic [3:0] fl);
        cfg = '{pol, pha, lsb, fl, 18'h5};
        cfg_we = 1;
        step();
        cfg_we = 0;
        step(3);
    endtask : setup
    task automatic xfer(input op_e o, input int n, hold,
                        input logic [15:0] tx, rep);
        logic [15:0] m;
        int got, k, tail, txn;
        m = 16'((32'h2 << cfg.flen) - 1);
        got = 0;
        txn = 0;
        tail = 8;
        reply = rep;
        clear = 1;
        step();
        clear = 0;
        op = o;
        count = n;
        tx_data = tx;
        tx_valid = (o != OP_READ);
        start = 1;
        step();
        start = 0;
        for (k = 0; k < 40000 && tail > 0; k++) begin
            rx_ready = (k >= hold);
            if (tx_ready) txn++;
            if (k == hold && hold > 0) chk("stall busy", 1, busy);
            if (rx_valid) begin
                chk("rx word", rep & m, rx_data);
                got++;
            end
            if (done || tail < 8) tail--;
            step();
        end
        tx_valid = 0;
        if (tail > 0) begin
            chk("timeout", 0, 1);
            close_out();
        end
        chk("rx count", (o == OP_WRITE) ? 0 : n, got);
        chk("tx taken", (o == OP_READ) ? 0 : n, txn);
        chk("slave frames", n, s_frames);
        if (n > 0)
            chk("slave word", (o == OP_READ) ? 0 : tx & m, s_word);
        chk("idle sck", cfg.cpol, sck);
        $display("test op %0d frames %0d over", o, n);
    endtask : xfer
    initial begin
        step(8);
        rst = 0;
        step();
        chk("reset sck", 0, sck);
        chk("reset busy", 0, busy);
        $display("test reset over");
        for (int i = 0; i < 4; i++) begin
            setup(i[1], i[0], i[0] ^ i[1], 4'(3 + 4 * i));
            xfer(OP_WRITE_READ, 2, 0, 16'h5a3c + 16'(i),
                 16'hc3a5 ^ 16'(i));
        end
        setup(1, 1, 0, 4'hf);
        xfer(OP_WRITE, 3, 0, 16'hbeef, 16'h0);
        setup(0, 1, 1, 4'h8);
        xfer(OP_READ, 10, 3000, 16'h0, 16'h1e7);
        xfer(OP_WRITE, 0, 0, 16'h1234, 16'h0);
        setup(0, 0, 0, 4'h2);
        chk("cfg err", 1, cfg_err);
        setup(1, 0, 0, 4'h7);
        chk("cfg ok", 0, cfg_err);
        $display("test config over");
        close = 1;
        step();
        close = 0;
        step(4);
        chk("close sck", 0, sck);
        chk("close busy", 0, busy);
        $display("test close over");
        close_out();
    end
endmodule : spi_master_channel_test
bind spi_master_channel spi_master_channel_properties u_props (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_close(i_close),
    .i_cfg_we(i_cfg_we), .i_cfg(i_cfg), .i_start(i_start),
    .i_frame_count(i_frame_count), .o_busy(o_busy), .o_done(o_done),
    .o_cfg_err(o_cfg_err), .o_sck(o_sck));
`default_nettype wire
